// *** hdl/mbl_pkg.sv ***
// message buffer lock arbiter: shared constants and types
// assumes a 32-bit classic wishbone slave with byte addresses
package mbl_pkg;

    // ********************************
    // sizes
    // ********************************
    localparam int unsigned NBUF      = 59;
    localparam int unsigned IDX_W     = 6;
    localparam int unsigned ADR_W     = 10;

    // ********************************
    // register offsets (byte addresses)
    // ********************************
    localparam logic [9:0] OFS_IRQ_STAT  = 10'h000;
    localparam logic [9:0] OFS_IRQ_MASK  = 10'h004;
    localparam logic [9:0] OFS_ERR       = 10'h008;
    localparam logic [9:0] OFS_CTRL      = 10'h00C;
    localparam logic [9:0] OFS_HELD      = 10'h010;
    localparam logic [9:0] OFS_FIFO_PTR  = 10'h014;
    localparam logic [9:0] OFS_BUF_BASE  = 10'h100;

    // ********************************
    // buffer register fields
    // ********************************
    localparam int unsigned BUF_LOCK_BIT   = 0;
    localparam int unsigned BUF_COMMIT_BIT = 1;
    localparam int unsigned BUF_TYPE_LO    = 2;

    // ********************************
    // irq status fields
    // ********************************
    localparam int unsigned IRQ_W          = 2;
    localparam int unsigned IRQ_HIF_ERR    = 0;
    localparam int unsigned IRQ_FRAME_LOST = 1;

    // ********************************
    // host interface error fields
    // ********************************
    localparam int unsigned ERR_W          = 7;
    localparam int unsigned ERR_TX_SECOND  = 0;
    localparam int unsigned ERR_RX_SECOND  = 1;
    localparam int unsigned ERR_FIFO_SECOND = 2;
    localparam int unsigned ERR_TX_BUSY    = 3;
    localparam int unsigned ERR_ODD_HALF   = 4;
    localparam int unsigned ERR_COMMITTED  = 5;
    localparam int unsigned ERR_FRAME_LOST = 6;

    // ********************************
    // reset values
    // ********************************
    localparam logic [IDX_W-1:0] RST_IDX  = 6'h00;
    localparam logic [31:0]      RST_DATA = 32'h0000_0000;
    localparam logic             RST_CFG  = 1'b1;

    // ********************************
    // buffer kinds
    // ********************************
    typedef enum logic [1:0] {
        MBL_FIFO,
        MBL_RX,
        MBL_STX,
        MBL_DTX
    } mbl_buf_type_t;

endpackage : mbl_pkg

// *** hdl/mbl_fifo_next.sv ***
// message buffer lock arbiter: next fifo buffer finder
// assumes buffer kinds arrive as a packed vector, two bits per buffer
`timescale 1ns/1ps
`default_nettype none
module mbl_fifo_next (
    // current pointer
    input  wire logic [mbl_pkg::IDX_W-1:0]      cur_i,
    // buffer kinds
    input  wire logic [2*mbl_pkg::NBUF-1:0]     types_i,
    // result
    output logic      [mbl_pkg::IDX_W-1:0]      next_o
);
    import mbl_pkg::*;

    // ********************************
    // circular search after cur_i
    // ********************************
    always_comb begin
        logic [IDX_W-1:0] cand;
        logic             found;
        cand   = cur_i;
        found  = 1'b0;
        next_o = cur_i;
        for (int k = 1; k <= NBUF; k++) begin
            cand = (32'(cur_i) + 32'(k) >= NBUF) ? IDX_W'(32'(cur_i) + 32'(k) - NBUF)
                                                  : IDX_W'(32'(cur_i) + 32'(k));
            if (!found && types_i[2*cand +: 2] == MBL_FIFO) begin
                next_o = cand;
                found  = 1'b1;
            end
        end
    end

endmodule : mbl_fifo_next
`default_nettype wire

// *** hdl/mbl_arbiter.sv ***
// message buffer lock arbiter: lock grant, active windows, errors, irq
// assumes a classic wishbone master and a protocol engine on one clock
//
// How it works
// - lock bit reads grant, writes request
// - refused lock sets irq flag and cause
// - second write of one releases at once
// - granted buffer mirrors into its kind window
// - one held buffer per window; second tx or rx lock is an error
// - fifo release advances the fifo pointer
// - lock never commits a buffer; tx release writes the commit bit it carries
// - odd half of double transmit refused
// - committed transmit buffer refused with error
// - second frame on held receive: frame lost
// - commit writable only while held in window
// - buffer in transmission refused, busy error
// - buffer kinds: fifo, rx, single, double tx
// - one control register per buffer index
`timescale 1ns/1ps
`default_nettype none
module mbl_arbiter (
    // clock and reset
    input  wire logic                          sys_clk_i,
    input  wire logic                          rst_i,
    // wishbone slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [mbl_pkg::ADR_W-1:0]     adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    // protocol engine
    input  wire logic                          tx_busy_i,
    input  wire logic [mbl_pkg::IDX_W-1:0]     tx_busy_idx_i,
    input  wire logic                          tx_done_i,
    input  wire logic [mbl_pkg::IDX_W-1:0]     tx_done_idx_i,
    input  wire logic                          rx_frame_i,
    input  wire logic [mbl_pkg::IDX_W-1:0]     rx_frame_idx_i,
    // active windows
    output logic                               act_tx_vld_o,
    output logic      [mbl_pkg::IDX_W-1:0]     act_tx_idx_o,
    output logic                               act_rx_vld_o,
    output logic      [mbl_pkg::IDX_W-1:0]     act_rx_idx_o,
    output logic                               act_fifo_vld_o,
    output logic      [mbl_pkg::IDX_W-1:0]     act_fifo_idx_o,
    // interrupt
    output logic                               irq_o
);
    import mbl_pkg::*;

    // ********************************
    // state
    // ********************************
    mbl_buf_type_t      type_q [NBUF];
    logic [NBUF-1:0]    commit_q;
    logic [2*NBUF-1:0]  types_flat;
    logic               tx_vld_q, rx_vld_q, fifo_vld_q;
    logic [IDX_W-1:0]   tx_idx_q, rx_idx_q, fifo_idx_q;
    logic [IDX_W-1:0]   fifo_ptr_q, fifo_ptr_d;
    logic               rx_pend_q;
    logic               cfg_q;
    logic [IRQ_W-1:0]   irq_stat_q, irq_mask_q;
    logic [ERR_W-1:0]   err_q;
    logic               ack_q;
    logic [31:0]        dat_q;
    logic               irq_q;

    // ********************************
    // bus decode
    // ********************************
    function automatic logic buf_hit(input logic [ADR_W-1:0] a);
        return (a >= OFS_BUF_BASE) && (a < OFS_BUF_BASE + ADR_W'(4 * NBUF));
    endfunction : buf_hit

    function automatic logic [IDX_W-1:0] buf_idx(input logic [ADR_W-1:0] a);
        logic [ADR_W-1:0] off;
        off = a - OFS_BUF_BASE;
        return off[IDX_W+1:2];
    endfunction : buf_idx

    logic             acc, wr, lock_wr, hit;
    logic [IDX_W-1:0] idx;
    mbl_buf_type_t    ty;
    logic             is_tx, is_rx, is_fifo;
    logic             held, rel, e_odd, e_cmt, e_busy, e_second, refuse, grant;
    logic [ERR_W-1:0] err_set;

    assign acc     = cyc_i && stb_i && !ack_q;
    assign wr      = acc && we_i;
    assign hit     = buf_hit(adr_i);
    assign idx     = buf_idx(adr_i);
    assign ty      = type_q[idx];
    assign is_tx   = (ty == MBL_STX) || (ty == MBL_DTX);
    assign is_rx   = (ty == MBL_RX);
    assign is_fifo = (ty == MBL_FIFO);
    assign lock_wr = wr && hit && sel_i[0] && dat_i[BUF_LOCK_BIT];

    // ********************************
    // lock decision
    // ********************************
    // a fifo lock always targets the buffer at the fifo pointer
    assign held     = (is_tx && tx_vld_q && tx_idx_q == idx)
                    || (is_rx && rx_vld_q && rx_idx_q == idx)
                    || (is_fifo && fifo_vld_q);
    assign rel      = lock_wr && held;
    assign e_odd    = (ty == MBL_DTX) && idx[0];
    assign e_cmt    = is_tx && commit_q[idx];
    assign e_busy   = is_tx && tx_busy_i && tx_busy_idx_i == idx;
    assign e_second = (is_tx && tx_vld_q) || (is_rx && rx_vld_q);
    assign refuse   = lock_wr && !held && (e_odd || e_cmt || e_busy || e_second);
    assign grant    = lock_wr && !held && !refuse;

    always_comb begin
        err_set = '0;
        if (refuse) begin
            err_set[ERR_ODD_HALF]    = e_odd;
            err_set[ERR_COMMITTED]   = e_cmt;
            err_set[ERR_TX_BUSY]     = e_busy;
            err_set[ERR_TX_SECOND]   = is_tx && tx_vld_q;
            err_set[ERR_RX_SECOND]   = is_rx && rx_vld_q;
        end
        if (rx_frame_i && rx_vld_q && rx_frame_idx_i == rx_idx_q && rx_pend_q) begin
            err_set[ERR_FRAME_LOST] = 1'b1;
        end
    end

    // ********************************
    // fifo pointer
    // ********************************
    mbl_fifo_next u_fifo_next (
        .cur_i   (fifo_ptr_q),
        .types_i (types_flat),
        .next_o  (fifo_ptr_d)
    );

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            fifo_ptr_q <= RST_IDX;
        end else if (rel && is_fifo) begin
            fifo_ptr_q <= fifo_ptr_d;
        end
    end

    // ********************************
    // per buffer kind and commit
    // ********************************
    for (genvar g = 0; g < NBUF; g++) begin : g_buf
        assign types_flat[2*g +: 2] = type_q[g];

        always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
                type_q[g] <= MBL_RX;
            end else if (wr && hit && idx == IDX_W'(g) && cfg_q && sel_i[0] && !refuse) begin
                type_q[g] <= mbl_buf_type_t'(dat_i[BUF_TYPE_LO +: 2]);
            end
        end

        always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
                commit_q[g] <= 1'b0;
            end else if (wr && hit && idx == IDX_W'(g) && sel_i[0]
                         && tx_vld_q && tx_idx_q == IDX_W'(g)) begin
                commit_q[g] <= dat_i[BUF_COMMIT_BIT];
            end else if (tx_done_i && tx_done_idx_i == IDX_W'(g)) begin
                commit_q[g] <= 1'b0;
            end
        end
    end

    // ********************************
    // held buffers (active windows)
    // ********************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_vld_q   <= 1'b0;
            tx_idx_q   <= RST_IDX;
            rx_vld_q   <= 1'b0;
            rx_idx_q   <= RST_IDX;
            fifo_vld_q <= 1'b0;
            fifo_idx_q <= RST_IDX;
        end else if (rel) begin
            if (is_tx) tx_vld_q <= 1'b0;
            if (is_rx) rx_vld_q <= 1'b0;
            if (is_fifo) fifo_vld_q <= 1'b0;
        end else if (grant) begin
            if (is_tx) begin
                tx_vld_q <= 1'b1;
                tx_idx_q <= idx;
            end
            if (is_rx) begin
                rx_vld_q <= 1'b1;
                rx_idx_q <= idx;
            end
            if (is_fifo) begin
                fifo_vld_q <= 1'b1;
                fifo_idx_q <= fifo_ptr_q;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_pend_q <= 1'b0;
        end else if ((grant || rel) && is_rx) begin
            rx_pend_q <= 1'b0;
        end else if (rx_frame_i && rx_vld_q && rx_frame_idx_i == rx_idx_q) begin
            rx_pend_q <= 1'b1;
        end
    end

    // ********************************
    // control, error and irq registers
    // ********************************
    logic wr_ctrl, wr_mask, wr_err, wr_isr;
    assign wr_ctrl = wr && adr_i == OFS_CTRL && sel_i[0];
    assign wr_mask = wr && adr_i == OFS_IRQ_MASK && sel_i[0];
    assign wr_err  = wr && adr_i == OFS_ERR && sel_i[0];
    assign wr_isr  = wr && adr_i == OFS_IRQ_STAT && sel_i[0];

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cfg_q <= RST_CFG;
        end else if (wr_ctrl) begin
            cfg_q <= dat_i[0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_mask_q <= '0;
        end else if (wr_mask) begin
            irq_mask_q <= dat_i[IRQ_W-1:0];
        end
    end

    // set wins over a write-one clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            err_q <= '0;
        end else begin
            err_q <= (err_q & ~(wr_err ? dat_i[ERR_W-1:0] : '0)) | err_set;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_isr ? dat_i[IRQ_W-1:0] : '0))
                        | {err_set[ERR_FRAME_LOST], refuse};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ********************************
    // wishbone answer
    // ********************************
    logic [31:0] rd_d;
    always_comb begin
        rd_d = RST_DATA;
        if (hit) begin
            rd_d[BUF_LOCK_BIT]        = held;
            rd_d[BUF_COMMIT_BIT]      = commit_q[idx];
            rd_d[BUF_TYPE_LO +: 2]    = ty;
        end else begin
            case (adr_i)
                OFS_IRQ_STAT: rd_d[IRQ_W-1:0] = irq_stat_q;
                OFS_IRQ_MASK: rd_d[IRQ_W-1:0] = irq_mask_q;
                OFS_ERR:      rd_d[ERR_W-1:0] = err_q;
                OFS_CTRL:     rd_d[0]         = cfg_q;
                OFS_HELD:     rd_d[23:0]      = {fifo_vld_q, 1'b0, fifo_idx_q,
                                                 rx_vld_q, 1'b0, rx_idx_q,
                                                 tx_vld_q, 1'b0, tx_idx_q};
                OFS_FIFO_PTR: rd_d[IDX_W-1:0] = fifo_ptr_q;
                default:      rd_d            = RST_DATA;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= RST_DATA;
        end else begin
            ack_q <= acc;
            if (acc && !we_i) begin
                dat_q <= rd_d;
            end
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign dat_o          = dat_q;
    assign ack_o          = ack_q;
    assign irq_o          = irq_q;
    assign act_tx_vld_o   = tx_vld_q;
    assign act_tx_idx_o   = tx_idx_q;
    assign act_rx_vld_o   = rx_vld_q;
    assign act_rx_idx_o   = rx_idx_q;
    assign act_fifo_vld_o = fifo_vld_q;
    assign act_fifo_idx_o = fifo_idx_q;

    // ********************************
    // assertions
    // ********************************
    sequence s_refused;
        refuse;
    endsequence

    sequence s_flagged;
        ##1 (irq_stat_q[IRQ_HIF_ERR] && err_q != '0);
    endsequence

    AST_REFUSE_FLAGS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_refused |-> s_flagged)
        else $error("refused lock did not raise error flags");
    AST_RELEASE_NOW: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rel && is_tx) |=> !act_tx_vld_o)
        else $error("tx release did not take effect next cycle");
    AST_GRANT_WIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (grant && is_rx) |=> (act_rx_vld_o && act_rx_idx_o == $past(idx)))
        else $error("rx grant not mirrored into rx window");
    AST_SECOND_TX: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (lock_wr && is_tx && tx_vld_q && tx_idx_q != idx)
        |=> (err_q[ERR_TX_SECOND] && $stable(act_tx_idx_o)))
        else $error("second tx lock not refused");
    AST_FIFO_ADV: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rel && is_fifo) |=> (fifo_ptr_q == $past(fifo_ptr_d)))
        else $error("fifo pointer did not advance on release");
    AST_NO_COMMIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (lock_wr && !dat_i[BUF_COMMIT_BIT] && !commit_q[idx]) |=> !commit_q[$past(idx)])
        else $error("lock or release committed a buffer");
    AST_ODD_HALF: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (lock_wr && !held && e_odd) |=> (err_q[ERR_ODD_HALF] && $stable(act_tx_vld_o)
                                         && $stable(act_tx_idx_o)))
        else $error("odd half of double tx was granted");
    AST_COMMITTED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (lock_wr && !held && e_cmt) |=> err_q[ERR_COMMITTED])
        else $error("committed tx buffer lock not flagged");
    AST_FRAME_LOST: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rx_frame_i && rx_vld_q && rx_frame_idx_i == rx_idx_q && rx_pend_q)
        |=> (err_q[ERR_FRAME_LOST] && irq_stat_q[IRQ_FRAME_LOST]))
        else $error("second frame on held rx not flagged");
    AST_BUSY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (lock_wr && !held && e_busy) |=> (err_q[ERR_TX_BUSY] && $stable(act_tx_vld_o)))
        else $error("busy tx buffer lock not refused");
    AST_ACK_ONE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle after request");

endmodule : mbl_arbiter
`default_nettype wire

// *** sim/mbl_engine_model.sv ***
// protocol engine model: transmit busy/done and frame arrivals
// assumes the bench pulses tx_go_i and rx_go_i for one cycle
`timescale 1ns/1ps
`default_nettype none
module mbl_engine_model (
    // clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    // bench commands
    input  wire logic                      tx_go_i,
    input  wire logic                      rx_go_i,
    input  wire logic [mbl_pkg::IDX_W-1:0] idx_i,
    // to the arbiter
    output logic                           tx_busy_o,
    output logic      [mbl_pkg::IDX_W-1:0] tx_idx_o,
    output logic                           tx_done_o,
    output logic                           rx_frame_o,
    output logic      [mbl_pkg::IDX_W-1:0] rx_idx_o
);
    import mbl_pkg::*;
    logic [4:0] cnt_q;
    // holds the buffer for 20 cycles, then releases it with done
    always_ff @(posedge sys_clk_i) begin
        tx_done_o <= 1'b0;
        if (rst_i) begin
            cnt_q     <= 5'h0;
            tx_busy_o <= 1'b0;
            tx_idx_o  <= 6'h3f;
        end else if (tx_go_i) begin
            cnt_q     <= 5'h14;
            tx_busy_o <= 1'b1;
            tx_idx_o  <= idx_i;
        end else if (cnt_q > 5'h1) begin
            cnt_q <= cnt_q - 5'h1;
        end else if (cnt_q == 5'h1) begin
            cnt_q     <= 5'h0;
            tx_busy_o <= 1'b0;
            tx_done_o <= 1'b1;
        end else begin
            tx_idx_o <= ~tx_idx_o;
        end
    end
    // one frame per command; idle index toggles
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_frame_o <= 1'b0;
            rx_idx_o   <= 6'h3f;
        end else begin
            rx_frame_o <= rx_go_i;
            rx_idx_o   <= rx_go_i ? idx_i : ~rx_idx_o;
        end
    end
endmodule : mbl_engine_model
`default_nettype wire

// *** sim/mbl_arbiter_tb.sv ***
// bench for the lock arbiter: wishbone master, queue-checked reads
// assumes the engine model on the protocol side
`timescale 1ns/1ps
`default_nettype none
module mbl_arbiter_tb;
    import mbl_pkg::*;
    logic             sys_clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic             tx_go = 1'b0, rx_go = 1'b0;
    logic [ADR_W-1:0] adr_i = '0;
    logic [31:0]      dat_i = '0, dat_o;
    logic [IDX_W-1:0] idx_c = '0, r;
    logic [IDX_W-1:0] t_idx, r_idx, tx_ix, rx_ix, ff_ix;
    logic             ack_o, t_busy, t_done, r_frm, tx_v, rx_v, ff_v, irq_o;
    logic [31:0]      exp_q[$];
    int               n_fail = 0, checks_done = 0, cyc_cnt = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    mbl_arbiter u_mbl_arbiter (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .tx_busy_i(t_busy), .tx_busy_idx_i(t_idx),
        .tx_done_i(t_done), .tx_done_idx_i(t_idx), .rx_frame_i(r_frm),
        .rx_frame_idx_i(r_idx), .act_tx_vld_o(tx_v), .act_tx_idx_o(tx_ix),
        .act_rx_vld_o(rx_v), .act_rx_idx_o(rx_ix), .act_fifo_vld_o(ff_v),
        .act_fifo_idx_o(ff_ix), .irq_o(irq_o));
    mbl_engine_model u_mbl_engine_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .tx_go_i(tx_go), .rx_go_i(rx_go), .idx_i(idx_c), .tx_busy_o(t_busy),
        .tx_idx_o(t_idx), .tx_done_o(t_done), .rx_frame_o(r_frm), .rx_idx_o(r_idx));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task final_report;
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("MISMATCH read queue expected 0 seen %0d", exp_q.size());
        end
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // read results checked against the oldest note
    always @(negedge sys_clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0)
            chk($sformatf("read %h", adr_i), exp_q.pop_front(), dat_o);
    end

    always @(posedge sys_clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int t;
        t = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge sys_clk_i);
        while (ack_o !== 1'b1 && t < 20) begin
            @(posedge sys_clk_i);
            t++;
        end
        if (ack_o !== 1'b1) chk("ack", 32'h1, 32'h0);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : wb

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd

    task automatic clr;
        wr(OFS_ERR, 32'h7f);
        wr(OFS_IRQ_STAT, 32'h3);
        rd(OFS_ERR, 32'h0);
    endtask : clr

    function automatic logic [9:0] ba(input int n);
        return OFS_BUF_BASE + 10'(n * 4);
    endfunction : ba

    initial begin
        void'($urandom(32'hab4e_81e9));
        r = 6'(8 + $urandom % 51);
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(OFS_CTRL, 32'h1);
        rd(10'h0f0, 32'h0);
        for (int i = 0; i < 8; i++) wr(ba(i), 32'(i / 2 * 4));
        wr(OFS_CTRL, 32'h0);
        wr(OFS_IRQ_MASK, 32'h3);
        rd(OFS_IRQ_MASK, 32'h3);
        $display("config done");
        wr(ba(r), 32'h5);
        rd(ba(r), 32'h5);
        chk("rx window", 32'({1'b1, r}), 32'({rx_v, rx_ix}));
        wr(ba(2), 32'h5);
        rd(ba(2), 32'h4);
        rd(OFS_ERR, 32'h2);
        rd(OFS_IRQ_STAT, 32'h1);
        rd(OFS_HELD, (32'(r) << 8) | 32'h8000);
        chk("irq", 32'h1, 32'(irq_o));
        wr(OFS_IRQ_MASK, 32'h0);
        chk("irq masked", 32'h0, 32'(irq_o));
        wr(OFS_IRQ_MASK, 32'h3);
        clr();
        idx_c <= r;
        repeat (2) begin
            rx_go <= 1'b1;
            @(posedge sys_clk_i);
            rx_go <= 1'b0;
            @(posedge sys_clk_i);
        end
        rd(OFS_ERR, 32'h40);
        rd(OFS_IRQ_STAT, 32'h2);
        clr();
        wr(ba(r), 32'h5);
        rd(ba(r), 32'h4);
        chk("rx released", 32'h0, 32'(rx_v));
        $display("rx tests done");
        wr(ba(7), 32'hd);
        rd(ba(7), 32'hc);
        rd(OFS_ERR, 32'h10);
        clr();
        wr(ba(6), 32'hd);
        chk("tx window", 32'({1'b1, 6'h6}), 32'({tx_v, tx_ix}));
        wr(ba(6), 32'hd);
        for (int i = 0; i < 2; i++) begin
            wr(ba(5), 32'h9);
            rd(ba(5), 32'h9);
            wr(ba(5), 32'h9);
            rd(ba(5), 32'h8);
        end
        wr(ba(4), 32'ha);
        rd(ba(4), 32'h8);
        wr(ba(4), 32'h9);
        wr(ba(4), 32'ha);
        rd(ba(4), 32'hb);
        wr(ba(4), 32'hb);
        wr(ba(4), 32'h9);
        rd(ba(4), 32'ha);
        rd(OFS_ERR, 32'h20);
        clr();
        idx_c <= 6'h4;
        tx_go <= 1'b1;
        @(posedge sys_clk_i);
        tx_go <= 1'b0;
        wr(ba(4), 32'h9);
        rd(OFS_ERR, 32'h28);
        repeat (24) @(posedge sys_clk_i);
        rd(ba(4), 32'h8);
        wr(ba(4), 32'h9);
        rd(ba(4), 32'h9);
        wr(ba(4), 32'h9);
        $display("tx tests done");
        rd(OFS_FIFO_PTR, 32'h0);
        wr(ba(1), 32'h1);
        chk("fifo window", 32'({1'b1, 6'h0}), 32'({ff_v, ff_ix}));
        wr(ba(1), 32'h1);
        rd(OFS_FIFO_PTR, 32'h1);
        wr(ba(0), 32'h1);
        chk("fifo window", 32'({1'b1, 6'h1}), 32'({ff_v, ff_ix}));
        wr(ba(0), 32'h1);
        rd(OFS_FIFO_PTR, 32'h0);
        $display("fifo tests done");
        final_report();
    end
endmodule : mbl_arbiter_tb
`default_nettype wire
